// ==== src/arfw_pkg.sv ====
// Package with register addresses, field positions and reset values of the result formatter.
package arfw_pkg;
    localparam int unsigned RESULT_BITS = 12;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned WORD_BITS = 16;

    localparam logic [7:0] ADDR_RESULT_LOW = 8'hbe;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hbf;
    localparam logic [7:0] ADDR_LESSER_LOW = 8'hc4;
    localparam logic [7:0] ADDR_GREATER_HIGH = 8'hc5;
    localparam logic [7:0] ADDR_GREATER_LOW = 8'hc6;
    localparam logic [7:0] ADDR_LESSER_HIGH = 8'hc7;
    localparam logic [7:0] ADDR_CONTROL = 8'he8;

    localparam int unsigned CTRL_LEFT_JUSTIFY_BIT = 0;
    localparam int unsigned CTRL_WINDOW_FLAG_BIT = 1;

    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [7:0] RST_GREATER_HIGH = 8'h00;
    localparam logic [7:0] RST_GREATER_LOW = 8'h00;
    localparam logic [7:0] RST_LESSER_HIGH = 8'h00;
    localparam logic [7:0] RST_LESSER_LOW = 8'hff;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ==== src/arfw_format.sv ====
// Combinational justification and sign extension of one conversion result.
`timescale 1ns/10ps
module arfw_format #(
    parameter int unsigned RES_W = arfw_pkg::RESULT_BITS
) (
    input wire logic [RES_W-1:0] conv_data,
    input wire logic conv_diff,
    input wire logic left_justify,
    output logic [15:0] word
);
    localparam int unsigned EXT_W = 16 - RES_W;

    logic [EXT_W-1:0] ext_bits;
    logic [15:0] right_word;
    logic [15:0] left_word;

    // Differential readings carry their sign into the unused top bits.
    assign ext_bits = conv_diff ? {EXT_W{conv_data[RES_W-1]}} : '0; // [RULE2]
    assign right_word = {ext_bits, conv_data}; // [RULE1]
    assign left_word = {conv_data, {EXT_W{1'b0}}}; // [RULE3]
    assign word = left_justify ? left_word : right_word; // [RULE4]
endmodule

// ==== src/arfw_top.sv ====
// Result formatting registers and window detector on the special-function-register bus.
// Behaviour
// RULE1 - Right justified: upper four bits in high byte 3..0, lower eight in low byte.
// RULE2 - Right justified: high byte 7..4 copy bit 3 if differential, else zero.
// RULE3 - Left justified: upper eight bits in high byte, lower four in low 7..4.
// RULE4 - Half-reference single-ended gives 0x0800 right or 0x8000 left justified.
// RULE5 - Every result is compared with the limits and flags window hits, inside or outside the band by RULE10.
// RULE6 - The window flag drives an interrupt request output.
// RULE7 - The window flag is readable in the control register for polling.
// RULE8 - Software writes each limit as separate high and low bytes.
// RULE9 - Limit ordering chooses whether inside or outside results set the flag.
// RULE10 - Lesser above greater: flag strictly between; otherwise above greater or below lesser.
// RULE11 - Lesser limit low byte resets to all ones and is read/write.
// RULE12 - Limits compare against the word in the currently selected justification.
`timescale 1ns/10ps
module arfw_top #(
    parameter int unsigned RES_W = arfw_pkg::RESULT_BITS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_data,
    input wire logic conv_diff,
    output logic window_irq
);
    logic [7:0] result_high_byte_reg;
    logic [7:0] result_low_byte_reg;
    logic [7:0] greater_limit_high_byte_reg;
    logic [7:0] greater_limit_low_byte_reg;
    logic [7:0] lesser_limit_high_byte_reg;
    logic [7:0] lesser_limit_low_byte_reg;
    logic left_justify_select_reg;
    logic window_compare_flag_reg;
    logic [7:0] sfr_rdata_reg;

    logic [7:0] sfr_rdata_next;
    logic window_compare_flag_next;
    logic [15:0] fmt_word;
    logic [15:0] greater_word;
    logic [15:0] lesser_word;
    logic above_greater;
    logic below_lesser;
    logic lesser_over_greater;
    logic window_hit;
    logic [7:0] control_value;
    logic wr_ctrl;
    logic wr_rh;
    logic wr_rl;
    logic wr_gh;
    logic wr_gl;
    logic wr_lh;
    logic wr_ll;

    // Address match for a write strobe.
    function automatic logic wr_hit(input logic [7:0] addr, input logic wr,
                                    input logic [7:0] target);
        wr_hit = wr && (addr == target);
    endfunction

    // Greater-than test; signed when the reading is differential.
    function automatic logic word_gt(input logic [15:0] a, input logic [15:0] b,
                                     input logic signed_mode);
        if (signed_mode) begin
            word_gt = $signed(a) > $signed(b);
        end else begin
            word_gt = a > b;
        end
    endfunction

    assign wr_ctrl = wr_hit(sfr_addr, sfr_wr, arfw_pkg::ADDR_CONTROL);
    assign wr_rh = wr_hit(sfr_addr, sfr_wr, arfw_pkg::ADDR_RESULT_HIGH);
    assign wr_rl = wr_hit(sfr_addr, sfr_wr, arfw_pkg::ADDR_RESULT_LOW);
    assign wr_gh = wr_hit(sfr_addr, sfr_wr, arfw_pkg::ADDR_GREATER_HIGH); // [RULE8]
    assign wr_gl = wr_hit(sfr_addr, sfr_wr, arfw_pkg::ADDR_GREATER_LOW); // [RULE8]
    assign wr_lh = wr_hit(sfr_addr, sfr_wr, arfw_pkg::ADDR_LESSER_HIGH); // [RULE8]
    assign wr_ll = wr_hit(sfr_addr, sfr_wr, arfw_pkg::ADDR_LESSER_LOW); // [RULE8]

    arfw_format #(
        .RES_W(RES_W)
    ) u_format (
        .conv_data(conv_data),
        .conv_diff(conv_diff),
        .left_justify(left_justify_select_reg), // [RULE12]
        .word(fmt_word)
    );

    assign greater_word = {greater_limit_high_byte_reg, greater_limit_low_byte_reg};
    assign lesser_word = {lesser_limit_high_byte_reg, lesser_limit_low_byte_reg};
    assign above_greater = word_gt(fmt_word, greater_word, conv_diff); // [RULE12]
    assign below_lesser = word_gt(lesser_word, fmt_word, conv_diff); // [RULE12]
    assign lesser_over_greater = word_gt(lesser_word, greater_word, conv_diff); // [RULE9]
    // Ordered limits pick an inside window, otherwise the two outer bands.
    assign window_hit = lesser_over_greater ? (above_greater && below_lesser)
                                            : (above_greater || below_lesser); // [RULE10]

    // A hit in the cycle of a software clear still sets the flag.
    assign window_compare_flag_next = (conv_done && window_hit) ? 1'b1 :
        (wr_ctrl ? sfr_wdata[arfw_pkg::CTRL_WINDOW_FLAG_BIT] : window_compare_flag_reg); // [RULE5]

    assign control_value = {6'h00, window_compare_flag_reg, left_justify_select_reg}; // [RULE7]

    assign sfr_rdata_next =
        (sfr_addr == arfw_pkg::ADDR_RESULT_LOW) ? result_low_byte_reg :
        (sfr_addr == arfw_pkg::ADDR_RESULT_HIGH) ? result_high_byte_reg :
        (sfr_addr == arfw_pkg::ADDR_GREATER_HIGH) ? greater_limit_high_byte_reg :
        (sfr_addr == arfw_pkg::ADDR_GREATER_LOW) ? greater_limit_low_byte_reg :
        (sfr_addr == arfw_pkg::ADDR_LESSER_HIGH) ? lesser_limit_high_byte_reg :
        (sfr_addr == arfw_pkg::ADDR_LESSER_LOW) ? lesser_limit_low_byte_reg : // [RULE11]
        (sfr_addr == arfw_pkg::ADDR_CONTROL) ? control_value :
        arfw_pkg::UNMAPPED_READ;

    // A finished conversion takes priority over a software write to the result bytes.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            result_high_byte_reg <= arfw_pkg::RST_RESULT;
            result_low_byte_reg <= arfw_pkg::RST_RESULT;
        end else if (conv_done) begin
            result_high_byte_reg <= fmt_word[15:8]; // [RULE1] [RULE3]
            result_low_byte_reg <= fmt_word[7:0]; // [RULE1] [RULE3]
        end else begin
            if (wr_rh) begin
                result_high_byte_reg <= sfr_wdata;
            end
            if (wr_rl) begin
                result_low_byte_reg <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            greater_limit_high_byte_reg <= arfw_pkg::RST_GREATER_HIGH;
            greater_limit_low_byte_reg <= arfw_pkg::RST_GREATER_LOW;
            lesser_limit_high_byte_reg <= arfw_pkg::RST_LESSER_HIGH;
            lesser_limit_low_byte_reg <= arfw_pkg::RST_LESSER_LOW; // [RULE11]
        end else begin
            if (wr_gh) begin
                greater_limit_high_byte_reg <= sfr_wdata;
            end
            if (wr_gl) begin
                greater_limit_low_byte_reg <= sfr_wdata;
            end
            if (wr_lh) begin
                lesser_limit_high_byte_reg <= sfr_wdata;
            end
            if (wr_ll) begin
                lesser_limit_low_byte_reg <= sfr_wdata; // [RULE11]
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            left_justify_select_reg <= 1'b0;
            window_compare_flag_reg <= 1'b0;
            sfr_rdata_reg <= arfw_pkg::RST_READ_DATA;
        end else begin
            if (wr_ctrl) begin
                left_justify_select_reg <= sfr_wdata[arfw_pkg::CTRL_LEFT_JUSTIFY_BIT];
            end
            window_compare_flag_reg <= window_compare_flag_next; // [RULE5]
            sfr_rdata_reg <= sfr_rdata_next; // [RULE7]
        end
    end

    assign sfr_rdata = sfr_rdata_reg;
    assign window_irq = window_compare_flag_reg; // [RULE6]

    sequence seq_right_conv;
        conv_done && !left_justify_select_reg && !wr_ctrl;
    endsequence

    sequence seq_left_conv;
        conv_done && left_justify_select_reg && !wr_ctrl;
    endsequence

    AST_RIGHT_PLACE: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE1]
        seq_right_conv |=> (result_low_byte_reg == $past(conv_data[7:0]))
            && (result_high_byte_reg[3:0] == $past(conv_data[11:8])))
        else $error("right justified placement wrong");

    AST_RIGHT_SIGN: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE2]
        seq_right_conv |=> result_high_byte_reg[7:4] ==
            ($past(conv_diff) ? {4{$past(conv_data[11])}} : 4'h0))
        else $error("right justified extension wrong");

    AST_LEFT_PLACE: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
        seq_left_conv |=> (result_high_byte_reg == $past(conv_data[11:4]))
            && (result_low_byte_reg == {$past(conv_data[3:0]), 4'h0}))
        else $error("left justified placement wrong");

    AST_HALF_SCALE: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE4]
        (conv_done && !conv_diff && conv_data == 12'h800 && !wr_ctrl) |=>
            ({result_high_byte_reg, result_low_byte_reg} ==
             ($past(left_justify_select_reg) ? 16'h8000 : 16'h0800)))
        else $error("half scale code wrong");

    AST_HIT_SETS: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE5]
        (conv_done && window_hit) |=> window_compare_flag_reg ##1 window_compare_flag_reg
            || $past(wr_ctrl))
        else $error("window hit lost");

    AST_IRQ_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE6]
        (conv_done && window_hit) |=> window_irq)
        else $error("no interrupt request after hit");

    AST_POLL_FLAG: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
        (sfr_addr == arfw_pkg::ADDR_CONTROL) |=>
            sfr_rdata[arfw_pkg::CTRL_WINDOW_FLAG_BIT] == $past(window_compare_flag_reg))
        else $error("flag not readable");

    AST_INSIDE_MODE: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE10]
        (conv_done && !conv_diff && lesser_word > greater_word && fmt_word > greater_word
            && fmt_word < lesser_word) |=> window_compare_flag_reg)
        else $error("inside window not flagged");

    AST_NO_HIT_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE5]
        (!(conv_done && window_hit) && !wr_ctrl) |=> $stable(window_compare_flag_reg))
        else $error("flag changed without cause");

    AST_LESSER_LOW_RW: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE11]
        wr_ll ##1 (sfr_addr == arfw_pkg::ADDR_LESSER_LOW && !sfr_wr) |=>
            sfr_rdata == $past(sfr_wdata, 2))
        else $error("lesser low byte readback wrong");

    AST_USES_FORMAT: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE12]
        (conv_done && !conv_diff && !lesser_over_greater && left_justify_select_reg
            && {conv_data, 4'h0} > greater_word) |=> window_compare_flag_reg)
        else $error("compare not on formatted word");
endmodule

// ==== testbench/arfw_core_model.sv ====
// Behavioural model of the conversion core that hands finished results to the formatter.
`timescale 1ns/10ps
module arfw_core_model (
    input wire logic sys_clk,
    output logic conv_done,
    output logic [11:0] conv_data,
    output logic conv_diff
);
    initial begin
        conv_done = 1'b0;
        conv_data = 12'h000;
        conv_diff = 1'b0;
    end

    // One result per call; data is inverted once the pulse ends so stale values never match.
    task automatic convert(input logic [11:0] d, input logic df);
        @(negedge sys_clk);
        conv_done = 1'b1;
        conv_data = d;
        conv_diff = df;
        @(negedge sys_clk);
        conv_done = 1'b0;
        conv_data = ~d;
        conv_diff = ~df;
    endtask
endmodule

// ==== testbench/tb_adc_result_format_window_detect.sv ====
// Self-checking testbench of the result formatter and window detector.
`timescale 1ns/10ps
module tb_adc_result_format_window_detect;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    wire logic [7:0] sfr_rdata;
    wire logic window_irq;
    wire logic conv_done;
    wire logic conv_diff;
    wire logic [11:0] conv_data;
    integer fails = 0;
    integer comparisons = 0;
    integer seed = 32'he69c;
    logic [7:0] exp_q[$];
    logic rd_flag = 1'b0;
    logic rd_take = 1'b0;
    logic [7:0] rst_addr[8] = '{8'hbe, 8'hbf, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'he8, 8'h00};
    logic [7:0] rst_val[8] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] lim_g[4] = '{16'h0100, 16'h0200, 16'h1000, 16'h2000};
    logic [15:0] lim_l[4] = '{16'h0200, 16'h0100, 16'h2000, 16'h1000};
    logic [11:0] win_d[16] = '{12'h100, 12'h101, 12'h1ff, 12'h200, 12'h0ff, 12'h100,
        12'h200, 12'h201, 12'h100, 12'h101, 12'h1ff, 12'h200, 12'h0ff, 12'h100,
        12'h200, 12'h201};

    always #5 sys_clk = ~sys_clk;

    arfw_top arfw_top_inst (.sys_clk(sys_clk), .nrst(nrst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .conv_done(conv_done), .conv_data(conv_data), .conv_diff(conv_diff),
        .window_irq(window_irq));
    arfw_core_model arfw_core_model_inst (.sys_clk(sys_clk), .conv_done(conv_done),
        .conv_data(conv_data), .conv_diff(conv_diff));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic complete_run;
        $display("counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask

    // The read data lands one edge after the address is taken.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        sfr_addr = a;
        exp_q.push_back(e);
        rd_flag = 1'b1;
        @(negedge sys_clk);
        rd_flag = 1'b0;
    endtask

    always @(posedge sys_clk) rd_take <= rd_flag;
    always @(negedge sys_clk) begin
        if (rd_take && exp_q.size() > 0) begin
            check({8'h00, sfr_rdata}, {8'h00, exp_q.pop_front()});
        end
    end

    function automatic logic [15:0] fmt(input logic [11:0] d, input logic df, input logic lj);
        return lj ? {d, 4'h0} : {{4{df & d[11]}}, d};
    endfunction

    function automatic logic hit(input logic [15:0] w, input logic [15:0] g, input logic [15:0] l);
        return (l > g) ? (w > g && w < l) : (w > g || w < l);
    endfunction

    initial begin
        #200000;
        fails++;
        complete_run();
    end

    initial begin
        logic [11:0] d;
        logic df;
        logic lj;
        logic e;
        logic [15:0] w;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(rst_addr[i], rst_val[i]);
        end
        wr(8'hc4, 8'h5a);
        rd(8'hc4, 8'h5a);
        wr(8'he8, 8'hff);
        rd(8'he8, 8'h03);
        wr(8'he8, 8'h00);
        rd(8'he8, 8'h00);
        // A reset in mid-run must bring the written lesser low byte back to all ones.
        @(negedge sys_clk);
        nrst = 1'b0;
        @(negedge sys_clk);
        nrst = 1'b1;
        rd(8'hc4, 8'hff);
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            d = (i < 2) ? 12'h800 : 12'($random(seed));
            df = (i < 2) ? 1'b0 : 1'($random(seed));
            lj = i[0];
            wr(8'he8, {7'h00, lj});
            arfw_core_model_inst.convert(d, df);
            w = fmt(d, df, lj);
            rd(8'hbf, w[15:8]);
            rd(8'hbe, w[7:0]);
        end
        $display("test formatting done");
        for (int c = 0; c < 4; c++) begin
            lj = (c >= 2);
            wr(8'hc5, lim_g[c][15:8]);
            wr(8'hc6, lim_g[c][7:0]);
            wr(8'hc7, lim_l[c][15:8]);
            wr(8'hc4, lim_l[c][7:0]);
            for (int k = 0; k < 4; k++) begin
                d = win_d[c * 4 + k];
                wr(8'he8, {7'h00, lj});
                arfw_core_model_inst.convert(d, 1'b0);
                e = hit(fmt(d, 1'b0, lj), lim_g[c], lim_l[c]);
                check({15'h0000, window_irq}, {15'h0000, e});
                rd(8'he8, {6'h00, e, lj});
            end
        end
        $display("test window done");
        for (int t = 0; t < 10 && exp_q.size() != 0; t++) begin
            @(negedge sys_clk);
        end
        if (exp_q.size() != 0) begin
            fails++;
        end
        complete_run();
    end
endmodule
